// >>> src/iocb_bank.sv
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - A read at offset zero returns the eight isolated inputs, input n in bit n.
// - Writes at offset one drive the eight isolated outputs and reads return the driven value.
// - Offset two holds read/write interrupt enables for input zero (bit 0) and input one (bit 1).
// - Offset five bits 0 and 1 choose which edge of inputs zero and one raises an event.
// - Offset nine passes reads and writes straight through to the second counter's data register.
// - Offset eleven passes writes to the counter chip control word for mode programming.
// - Each counter has a start register: bit 0 drives its gate, bit 4 reads back its output level.
// - The counter zero settings register bits 0..3 pick clock source, gate source, output and interrupt routing.
module iocb_bank
(
    input  wire logic                clk_sys,
    input  wire logic                arst_n,
    input  wire iocb_pkg::iocb_req_s req,
    output logic [7:0]               rdata,
    input  wire logic [7:0]          iso_in,
    output logic [7:0]               iso_out,
    output iocb_pkg::iocb_tmr_s      tmr_req,
    input  wire logic [7:0]          tmr_rdata,
    input  wire logic                timer_zero_level,
    input  wire logic                timer_one_level,
    output logic                     timer_zero_run,
    output logic                     timer_one_run,
    output iocb_pkg::iocb_cfg_s      cfg,
    output logic                     irq
);
    import iocb_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [7:0] in_s1;
        logic [7:0] in_s2;
        logic [1:0] in_prev;
        logic [1:0] lvl_s1;
        logic [1:0] lvl_s2;
        logic [1:0] lvl_prev;
        logic [7:0] output_drive;
        logic [7:0] irq_enable;
        logic [7:0] irq_edge_select;
        logic [7:0] irq_flags;
        logic [7:0] irq_mask;
        logic [7:0] t0_start;
        logic [7:0] t1_start;
        iocb_cfg_s  cfg;
        logic       rd_tmr;
        logic [7:0] rdata;
        logic       irq;
    } iocb_state_s;

    iocb_state_s st;
    iocb_state_s next_st;

    // edge event: sel=1 rising, sel=0 falling
    function automatic logic edge_hit(input logic prev, input logic cur, input logic sel);
        edge_hit = sel ? (cur & ~prev) : (prev & ~cur);
    endfunction

    function automatic logic is_timer_addr(input logic [7:0] a);
        is_timer_addr = (a == OFS_TIMER_ZERO_DATA) || (a == OFS_TIMER_ONE_DATA) || (a == OFS_TIMER_CTRL_WORD);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // next state

    logic [7:0] events;
    logic [7:0] rd_mux;

    always_comb
    begin
        next_st = st;
        events  = RST_BYTE;
        rd_mux  = RST_BYTE;

        // two-stage synchronisers; only stage two feeds logic
        next_st.in_s1  = iso_in;
        next_st.in_s2  = st.in_s1;
        next_st.lvl_s1 = {timer_one_level, timer_zero_level};
        next_st.lvl_s2 = st.lvl_s1;
        next_st.in_prev  = st.in_s2[1:0];
        next_st.lvl_prev = st.lvl_s2;

        events[FLG_IN0] = edge_hit(st.in_prev[0], st.in_s2[0], st.irq_edge_select[0]);
        events[FLG_IN1] = edge_hit(st.in_prev[1], st.in_s2[1], st.irq_edge_select[1]);
        // counter events on rising output, only when routed to interrupt
        events[FLG_T0] = st.lvl_s2[0] & ~st.lvl_prev[0] & st.cfg.t0_route[3];
        events[FLG_T1] = st.lvl_s2[1] & ~st.lvl_prev[1] & st.cfg.t1_route[3];

        if (req.wr)
        begin
            unique case (req.addr)
                OFS_OUTPUT_DRIVE:     next_st.output_drive = req.wdata;
                OFS_IRQ_ENABLE:       next_st.irq_enable = req.wdata & ENA_BITS;
                OFS_IRQ_EDGE_SELECT:  next_st.irq_edge_select = req.wdata & ENA_BITS;
                OFS_IRQ_FLAGS:        next_st.irq_flags = st.irq_flags & ~req.wdata;
                OFS_TIMER_ZERO_START: next_st.t0_start = req.wdata & START_BITS;
                OFS_TIMER_ONE_START:  next_st.t1_start = req.wdata & START_BITS;
                OFS_TIMER_ZERO_ROUTE: next_st.cfg.t0_route = req.wdata & ROUTE0_BITS;
                OFS_TIMER_ONE_ROUTE:  next_st.cfg.t1_route = req.wdata & ROUTE1_BITS;
                OFS_LIGHT_CTRL:       next_st.cfg.light = req.wdata & PAT_BITS;
                OFS_BEEPER_CTRL:      next_st.cfg.beeper = req.wdata & PAT_BITS;
                OFS_IRQ_MASK:         next_st.irq_mask = req.wdata & FLAG_BITS;
                default:              next_st.irq_mask = st.irq_mask;
            endcase
        end
        // set wins over a clear in the same cycle
        next_st.irq_flags = (next_st.irq_flags | events) & FLAG_BITS;

        unique case (req.addr)
            OFS_INPUT_STATE:      rd_mux = st.in_s2;
            OFS_OUTPUT_DRIVE:     rd_mux = st.output_drive;
            OFS_IRQ_ENABLE:       rd_mux = st.irq_enable;
            OFS_IRQ_EDGE_SELECT:  rd_mux = st.irq_edge_select;
            OFS_IRQ_FLAGS:        rd_mux = st.irq_flags;
            OFS_TIMER_ZERO_START: rd_mux = st.t0_start | ({7'h00, st.lvl_s2[0]} << FLD_LEVEL);
            OFS_TIMER_ONE_START:  rd_mux = st.t1_start | ({7'h00, st.lvl_s2[1]} << FLD_LEVEL);
            OFS_TIMER_ZERO_ROUTE: rd_mux = st.cfg.t0_route;
            OFS_TIMER_ONE_ROUTE:  rd_mux = st.cfg.t1_route;
            OFS_LIGHT_CTRL:       rd_mux = st.cfg.light;
            OFS_BEEPER_CTRL:      rd_mux = st.cfg.beeper;
            OFS_IRQ_MASK:         rd_mux = st.irq_mask;
            default:              rd_mux = RST_BYTE;
        endcase

        // counter chip data arrives in the cycle after the strobe, so the bank
        // picks it up combinationally in the answer cycle
        next_st.rd_tmr = req.rd & is_timer_addr(req.addr);
        next_st.rdata  = req.rd ? rd_mux : RST_BYTE;

        // interrupt only for flag with mask bit, inputs also need their enable; counters use the mask alone
        next_st.irq = |(next_st.irq_flags & st.irq_mask
                        & {4'h0, 2'b11, next_st.irq_enable[1:0]});
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st          <= '0;
            st.irq_mask <= RST_MASK & FLAG_BITS;
        end
        else
        begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    always_comb
    begin
        tmr_req.sel   = req.addr[1:0];
        tmr_req.wdata = req.wdata;
        tmr_req.wr    = req.wr & is_timer_addr(req.addr);
        tmr_req.rd    = req.rd & is_timer_addr(req.addr);
    end

    assign rdata          = st.rd_tmr ? tmr_rdata : st.rdata;
    assign iso_out        = st.output_drive;
    assign timer_zero_run = st.t0_start[FLD_RUN];
    assign timer_one_run  = st.t1_start[FLD_RUN];
    assign cfg            = st.cfg;
    assign irq            = st.irq;

endmodule

`default_nettype wire

// >>> src/iocb_pkg.sv
package iocb_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // register offsets
    localparam logic [7:0] OFS_INPUT_STATE      = 8'h00;
    localparam logic [7:0] OFS_OUTPUT_DRIVE     = 8'h01;
    localparam logic [7:0] OFS_IRQ_ENABLE       = 8'h02;
    localparam logic [7:0] OFS_IRQ_EDGE_SELECT  = 8'h05;
    localparam logic [7:0] OFS_IRQ_FLAGS        = 8'h07;
    localparam logic [7:0] OFS_TIMER_ZERO_DATA  = 8'h08;
    localparam logic [7:0] OFS_TIMER_ONE_DATA   = 8'h09;
    localparam logic [7:0] OFS_TIMER_CTRL_WORD  = 8'h0b;
    localparam logic [7:0] OFS_TIMER_ZERO_START = 8'h0c;
    localparam logic [7:0] OFS_TIMER_ONE_START  = 8'h0d;
    localparam logic [7:0] OFS_TIMER_ZERO_ROUTE = 8'h0e;
    localparam logic [7:0] OFS_TIMER_ONE_ROUTE  = 8'h0f;
    localparam logic [7:0] OFS_LIGHT_CTRL       = 8'h10;
    localparam logic [7:0] OFS_BEEPER_CTRL      = 8'h11;
    localparam logic [7:0] OFS_IRQ_MASK         = 8'h12;

    // field positions
    localparam int FLD_RUN    = 0;
    localparam int FLD_LEVEL  = 4;
    localparam int FLG_IN0    = 0;
    localparam int FLG_IN1    = 1;
    localparam int FLG_T0     = 2;
    localparam int FLG_T1     = 3;

    // reset values and writable-bit masks
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] RST_MASK = 8'hff;
    localparam logic [7:0] FLAG_BITS  = 8'h0f;
    localparam logic [7:0] ENA_BITS   = 8'h03;
    localparam logic [7:0] START_BITS = 8'h01;
    localparam logic [7:0] ROUTE0_BITS = 8'h0f;
    localparam logic [7:0] ROUTE1_BITS = 8'h7f;
    localparam logic [7:0] PAT_BITS   = 8'h07;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } iocb_req_s;

    // access towards the external interval counter chip
    typedef struct packed {
        logic [1:0] sel;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } iocb_tmr_s;

    typedef struct packed {
        logic [7:0] t0_route;
        logic [7:0] t1_route;
        logic [7:0] light;
        logic [7:0] beeper;
    } iocb_cfg_s;

endpackage

// >>> verification/iocb_bank_checker.sv
`timescale 1ns/1ps
`default_nettype none
module iocb_bank_checker
(
    input wire logic                clk_sys,
    input wire logic                arst_n,
    input wire iocb_pkg::iocb_req_s req,
    input wire logic [7:0]          rdata,
    input wire logic [7:0]          iso_in,
    input wire logic [7:0]          iso_out,
    input wire iocb_pkg::iocb_tmr_s tmr_req,
    input wire logic [7:0]          tmr_rdata,
    input wire logic                timer_zero_level,
    input wire logic                timer_one_level,
    input wire logic                timer_zero_run,
    input wire logic                timer_one_run,
    input wire iocb_pkg::iocb_cfg_s cfg,
    input wire logic                irq
);
    import iocb_pkg::*;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);
////////////////////////////////////////
    // inputs pass two sync stages, so only a read of a settled input is judged
    a_in_state_read: assert property (
        req.rd && req.addr == 8'h00 && $stable(iso_in) && $past(iso_in, 2) == iso_in && $past(iso_in, 3) == iso_in
        |=> rdata == $past(iso_in)) else $error("input read wrong");
    a_out_drive_write: assert property (
        req.wr && req.addr == 8'h01 |=> iso_out == $past(req.wdata)) else $error("output drive wrong");
    a_enable_read_back: assert property (
        req.wr && req.addr == 8'h02 ##1 !req.wr ##1 req.rd && req.addr == 8'h02
        |=> rdata[1:0] == $past(req.wdata[1:0], 3)) else $error("enable read wrong");
    a_edge_read_back: assert property (
        req.wr && req.addr == 8'h05 ##1 !req.wr ##1 req.rd && req.addr == 8'h05
        |=> rdata[1:0] == $past(req.wdata[1:0], 3)) else $error("edge read wrong");
    a_timer_write_pass: assert property (
        req.wr && (req.addr == 8'h09 || req.addr == 8'h0b)
        |-> tmr_req.wr && tmr_req.sel == req.addr[1:0] && tmr_req.wdata == req.wdata) else $error("timer write wrong");
    a_timer_read_pass: assert property (
        req.rd && req.addr == 8'h09 |-> tmr_req.rd ##1 rdata == tmr_rdata) else $error("timer read wrong");
    a_gate_from_write: assert property (
        req.wr && req.addr == 8'h0d |=> timer_one_run == $past(req.wdata[0])) else $error("gate wrong");
    a_route_from_write: assert property (
        req.wr && req.addr == 8'h0e |=> cfg.t0_route[3:0] == $past(req.wdata[3:0])) else $error("route wrong");
    c_flag_clear: cover property (req.wr && req.addr == 8'h07);
    c_irq_rise: cover property ($rose(irq));
    c_start_read: cover property (req.rd && req.addr == 8'h0d);
endmodule
bind iocb_bank iocb_bank_checker chk_u (.clk_sys, .arst_n, .req, .rdata, .iso_in, .iso_out, .tmr_req, .tmr_rdata,
    .timer_zero_level, .timer_one_level, .timer_zero_run, .timer_one_run, .cfg, .irq);
`default_nettype wire

// >>> verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import iocb_pkg::*;
    logic      clk_sys = 1'b0;
    logic      arst_n = 1'b0;
    iocb_req_s req = '0;
    logic [7:0] rdata, iso_out, iso_in = 8'h00, tmr_rdata = 8'h3c;
    logic      timer_zero_level = 1'b0, timer_one_level = 1'b0, timer_zero_run, timer_one_run, irq;
    iocb_tmr_s tmr_req;
    iocb_cfg_s cfg;
    int        fail_count = 0;
    int        samples_checked = 0;
    iocb_bank dut_u (.clk_sys, .arst_n, .req, .rdata, .iso_in, .iso_out, .tmr_req, .tmr_rdata,
        .timer_zero_level, .timer_one_level, .timer_zero_run, .timer_one_run, .cfg, .irq);
////////////////////////////////////////
    initial
    begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        req.wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
        @(posedge clk_sys);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        req.rd <= 1'b0;
        #1 check(name, exp, rdata);
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        #20000;
        fail_count++;
        print_verdict;
    end
    initial
    begin
        repeat (6) @(posedge clk_sys);
        arst_n <= 1'b1;
        wr(8'h01, 8'ha5);
        #1 check("iso_out", 8'ha5, iso_out);
        rd(8'h01, 8'ha5, "output_drive");
        @(posedge clk_sys);
        iso_in <= 8'h96;
        repeat (4) @(posedge clk_sys);
        wr(8'h00, 8'hff);
        rd(8'h00, 8'h96, "input_state");
        rd(8'h03, 8'h00, "unmapped");
        $display("test io done");
        wr(8'h02, 8'h03);
        rd(8'h02, 8'h03, "irq_enable");
        wr(8'h05, 8'h01);
        rd(8'h05, 8'h01, "irq_edge_select");
        wr(8'h09, 8'h5a);
        rd(8'h09, 8'h3c, "timer_one_data");
        rd(8'h08, 8'h3c, "timer_zero_data");
        wr(8'h0b, 8'h36);
        wr(8'h0d, 8'h01);
        #1 check("timer_one_run", 8'h01, {7'h00, timer_one_run});
        wr(8'h0c, 8'h01);
        #1 check("timer_zero_run", 8'h01, {7'h00, timer_zero_run});
        timer_one_level <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rd(8'h0d, 8'h11, "timer_one_start");
        wr(8'h0e, 8'h0f);
        #1 check("t0_route", 8'h0f, cfg.t0_route);
        wr(8'h10, 8'h07);
        #1 check("light", 8'h07, cfg.light);
        wr(8'h11, 8'h05);
        #1 check("beeper", 8'h05, cfg.beeper);
        wr(8'h0f, 8'h7f);
        #1 check("t1_route", 8'h7f, cfg.t1_route);
        $display("test regs done");
        wr(8'h07, 8'h0f);
        rd(8'h07, 8'h00, "irq_flags");
        // bit 0 rises and bit 1 falls, matching the chosen edges
        @(posedge clk_sys);
        iso_in <= 8'h95;
        repeat (5) @(posedge clk_sys);
        #1 check("irq", 8'h01, {7'h00, irq});
        rd(8'h07, 8'h03, "irq_flags");
        wr(8'h02, 8'h00);
        repeat (2) @(posedge clk_sys);
        #1 check("irq", 8'h00, {7'h00, irq});
        wr(8'h07, 8'h03);
        rd(8'h07, 8'h00, "irq_flags");
        @(posedge clk_sys);
        timer_zero_level <= 1'b1;
        repeat (5) @(posedge clk_sys);
        #1 check("irq", 8'h01, {7'h00, irq});
        rd(8'h07, 8'h04, "irq_flags");
        $display("test irq done");
        print_verdict;
    end
endmodule
`default_nettype wire
